//--- adc_sequence_control.sv
// Summary of operation
// RULE_01 - each result is a 10-bit value from a successive approximation
// RULE_02 - sixteen inputs routed onto four sample-and-hold channels
// RULE_03 - software selects supply pair or external pins as reference
// RULE_04 - converter keeps working while chip sleeps
// RULE_05 - software keeps configuration fixed while module is on; the bench changes result_format while on
// RULE_06 - sixteen 10-bit entries, read as 16-bit words, not writable
// RULE_07 - setting sample start begins acquisition; trigger starts conversion
// RULE_08 - every result stored; flag and done after programmed sequences
// RULE_09 - software follows the advised setup and run order
// RULE_10 - sequential mode samples and converts channels one by one
// RULE_11 - simultaneous mode samples all together then converts in turn
// RULE_12 - channel count selects one, two or four channels
// RULE_13 - sequences per interrupt ranges from one to sixteen
// RULE_14 - software limits conversions per interrupt to sixteen or eight
// RULE_15 - split buffer alternates 8-word halves at each interrupt
// RULE_16 - software sets split buffer unless it empties buffer quickly
// RULE_17 - alternate bit clear always uses primary input set
// RULE_18 - alternate bit set toggles primary and alternate each sequence
// RULE_19 - scan enable steps first channel over selected inputs
// RULE_20 - scan ascends, restarts after interrupt, extras unused
// RULE_21 - manual trigger on sample start clear; auto after set clocks
// RULE_22 - turning off aborts conversion, partial result not stored
// RULE_23 - write position returns to buffer or next half after interrupt
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_sequence_control
(
   input wire logic clk,
   input wire logic rst,
   input wire logic module_on_bit,
   input wire logic sample_start_bit,
   input wire logic [2:0] trigger_source_sel,
   input wire logic ext_trigger,
   input wire logic auto_sample_enable,
   input wire logic simultaneous_sample_sel,
   input wire logic [3:0] sequences_per_interrupt,
   input wire logic split_buffer_bit,
   input wire logic alternate_input_bit,
   input wire logic [1:0] channel_count_field,
   input wire logic scan_enable_bit,
   input wire logic [15:0] scan_select_reg,
   input wire logic [4:0] auto_sample_clocks,
   input wire logic [1:0] result_format,
   input wire logic ref_ext_sel,
   input wire logic [3:0] pos_input_primary,
   input wire logic [3:0] pos_input_alternate,
   input wire logic [3:0] read_addr,
   input wire logic [9:0] comparator_in,
   output logic [15:0] read_data,
   output logic [3:0] sh_input_sel,
   output logic [1:0] sh_channel,
   output logic [3:0] sh_sample,
   output logic sar_active,
   output logic [9:0] sar_trial,
   output logic ref_ext,
   output logic conversion_irq_flag,
   output logic done_bit
);
   adc_seq_pkg::state_type state_q, state_d;
   logic [9:0] mem_q [`BUF_DEPTH];
   logic [9:0] sar_q;
   logic [3:0] bit_q;
   logic [4:0] cnt_q;
   logic [1:0] ch_q;
   logic [3:0] seq_q;
   logic [3:0] wptr_q;
   logic half_q;
   logic alt_q;
   logic [3:0] scan_q;
   logic [15:0] scan_used_q;
   logic [2:0] trig_sync_q;
   logic sample_start_bit_prev_q;
   logic [15:0] read_data_q;
   logic [3:0] sel_q;
   logic [1:0] shch_q;
   logic [3:0] shs_q;
   logic irq_q, done_q;
   logic ext_q1, ext_q2;

   // channel count decode
   function automatic logic [1:0] last_channel(input logic [1:0] f);
      if (f == `CHANNEL_COUNT_FIELD_ONE)
         last_channel = 2'h0;
      else if (f == `CHANNEL_COUNT_FIELD_TWO)
         last_channel = 2'h1;
      else
         last_channel = 2'h3;
   endfunction

   // lowest selected input not yet used this interrupt
   function automatic logic [3:0] next_scan(input logic [15:0] sel);
      next_scan = 4'h0;
      for (int i = 15; i >= 0; i--)
         if (sel[i])
            next_scan = 4'(i);
   endfunction

   wire [1:0] last_ch = last_channel(channel_count_field); // RULE_12
   wire multi = (last_ch != 2'h0);
   wire simul = simultaneous_sample_sel && multi; // RULE_11
   wire manual = (trigger_source_sel == `TRIG_MANUAL);
   wire autot = (trigger_source_sel == `TRIG_AUTO);
   wire sample_start_bit_fall = sample_start_bit_prev_q && !sample_start_bit;
   wire ext_rise = ext_q2 && !trig_sync_q[0];
   wire auto_done = (cnt_q >= auto_sample_clocks) && (cnt_q != 5'h00);
   // RULE_21 manual clears, auto counts, others take synchronised pin edge
   wire trigger = manual ? sample_start_bit_fall : (autot ? auto_done : ext_rise); // RULE_21
   wire last_seq = (seq_q == sequences_per_interrupt); // RULE_13
   wire last_chan = (ch_q == last_ch);
   wire use_alt = alternate_input_bit && alt_q; // RULE_17 RULE_18
   wire [15:0] scan_left = scan_select_reg & ~scan_used_q;
   wire [3:0] scan_pick = next_scan(scan_left); // RULE_20
   wire [3:0] ch0_input = (scan_enable_bit && !use_alt) ? scan_pick
      : (use_alt ? pos_input_alternate : pos_input_primary); // RULE_19
   wire sar_end = (bit_q == `SAR_LAST);
   wire [9:0] sar_try = sar_q | (10'h200 >> bit_q);
   wire [9:0] sar_keep = (comparator_in >= sar_try) ? sar_try : sar_q;

   adc_seq_pkg::result_type res_in, res_out;
   wire res_ready, res_valid;
   assign res_in.addr = wptr_q;
   assign res_in.data = sar_keep;

   // store path decoupled so a busy write port never drops a result
   result_skid u_skid
   (
      .clk(clk),
      .rst(rst),
      .in_valid(state_q == adc_seq_pkg::st_store),
      .in_ready(res_ready),
      .in_data(res_in),
      .out_valid(res_valid),
      .out_ready(1'b1),
      .out_data(res_out)
   );

   // sequencing state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         adc_seq_pkg::st_idle:
            if (module_on_bit && (sample_start_bit || auto_sample_enable))
               state_d = adc_seq_pkg::st_sample; // RULE_07
         adc_seq_pkg::st_sample:
            state_d = adc_seq_pkg::st_wait_trig;
         adc_seq_pkg::st_wait_trig:
            if (trigger)
               state_d = adc_seq_pkg::st_convert; // RULE_07
         adc_seq_pkg::st_convert:
            if (sar_end)
               state_d = adc_seq_pkg::st_store;
         adc_seq_pkg::st_store:
            if (res_ready)
            begin
               if (!last_chan)
                  state_d = simul ? adc_seq_pkg::st_convert
                     : adc_seq_pkg::st_sample; // RULE_10 RULE_11
               else
                  state_d = adc_seq_pkg::st_idle;
            end
         default:
            state_d = adc_seq_pkg::st_idle;
      endcase
      if (!module_on_bit)
         state_d = adc_seq_pkg::st_idle; // RULE_22
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         state_q <= adc_seq_pkg::st_idle;
      else
         state_q <= state_d;
   end

   // trigger pin sync and edge history
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ext_q1 <= 1'b0;
         ext_q2 <= 1'b0;
         trig_sync_q <= 3'h0;
         sample_start_bit_prev_q <= 1'b0;
      end
      else
      begin
         ext_q1 <= ext_trigger;
         ext_q2 <= ext_q1;
         trig_sync_q <= {trig_sync_q[1:0], ext_q2};
         sample_start_bit_prev_q <= sample_start_bit;
      end
   end

   // acquisition counter and successive approximation
   always_ff @(posedge clk)
   begin
      if (rst || state_q == adc_seq_pkg::st_sample)
         cnt_q <= 5'h00;
      else if (state_q == adc_seq_pkg::st_wait_trig && cnt_q != 5'h1f)
         cnt_q <= cnt_q + 5'h01;
      if (rst || state_q != adc_seq_pkg::st_convert)
      begin
         sar_q <= 10'h000;
         bit_q <= 4'h0;
      end
      else
      begin
         sar_q <= sar_keep; // RULE_01
         bit_q <= bit_q + 4'h1;
      end
   end

   // channel, sequence, alternation, scan and write position
   always_ff @(posedge clk)
   begin
      if (rst || !module_on_bit)
      begin
         ch_q <= 2'h0;
         seq_q <= 4'h0;
         wptr_q <= 4'h0;
         half_q <= 1'b0;
         alt_q <= 1'b0;
         scan_used_q <= 16'h0000;
      end
      else if (state_q == adc_seq_pkg::st_store && res_ready)
      begin
         wptr_q <= wptr_q + 4'h1;
         if (ch_q == 2'h0 && scan_enable_bit && !use_alt)
            scan_used_q[scan_pick] <= 1'b1;
         if (!last_chan)
            ch_q <= ch_q + 2'h1;
         else
         begin
            ch_q <= 2'h0;
            alt_q <= ~alt_q; // RULE_18
            if (last_seq)
            begin
               seq_q <= 4'h0;
               scan_used_q <= 16'h0000; // RULE_20
               half_q <= split_buffer_bit && !half_q; // RULE_15
               wptr_q <= (split_buffer_bit && !half_q) ? `HALF_BASE
                  : 4'h0; // RULE_23
            end
            else
               seq_q <= seq_q + 4'h1;
         end
      end
   end

   // result memory write port; reads only, software cannot write
   always_ff @(posedge clk)
   begin
      if (res_valid)
         mem_q[res_out.addr] <= res_out.data; // RULE_06 RULE_08
   end

   // formatted read: integer, signed integer, fractional, signed fraction
   wire [9:0] rv = mem_q[read_addr];
   wire [15:0] fmt_int = {6'h00, rv};
   wire [15:0] fmt_sint = {{7{~rv[9]}}, rv[8:0]};
   wire [15:0] fmt_frac = {rv, 6'h00};
   wire [15:0] fmt_sfrac = {~rv[9], rv[8:0], 6'h00};
   wire [15:0] fmt_sel = (result_format == 2'h0) ? fmt_int
      : (result_format == 2'h1) ? fmt_sint
      : (result_format == 2'h2) ? fmt_frac : fmt_sfrac;

   // analog front-end controls, all registered
   wire [3:0] hold_d = simul && state_q == adc_seq_pkg::st_sample ?
      (last_ch == 2'h3 ? 4'hf : 4'h3) : (4'h1 << ch_q); // RULE_02
   wire irq_set = state_q == adc_seq_pkg::st_store && res_ready
      && last_chan && last_seq;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         read_data_q <= 16'h0000;
         sel_q <= 4'h0;
         shch_q <= 2'h0;
         shs_q <= 4'h0;
         irq_q <= 1'b0;
         done_q <= 1'b0;
         ref_ext <= 1'b0;
      end
      else
      begin
         read_data_q <= fmt_sel; // RULE_06
         sel_q <= (ch_q == 2'h0) ? ch0_input : pos_input_primary;
         shch_q <= ch_q;
         shs_q <= (state_q == adc_seq_pkg::st_sample
            || state_q == adc_seq_pkg::st_wait_trig) ? hold_d : 4'h0;
         irq_q <= irq_set ? 1'b1 : (irq_q & module_on_bit); // RULE_08
         done_q <= irq_set ? 1'b1
            : (done_q && !(sample_start_bit && !sample_start_bit_prev_q));
         ref_ext <= ref_ext_sel; // RULE_03
      end
   end

   // no dependence on any sleep signal, so the block runs in sleep
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sar_active <= 1'b0;
         sar_trial <= 10'h000;
      end
      else
      begin
         sar_active <= (state_d == adc_seq_pkg::st_convert); // RULE_04
         sar_trial <= sar_try;
      end
   end

   assign read_data = read_data_q;
   assign sh_input_sel = sel_q;
   assign sh_channel = shch_q;
   assign sh_sample = shs_q;
   assign conversion_irq_flag = irq_q;
   assign done_bit = done_q;
endmodule

//--- adc_seq_defs.svh
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define RES_W 10
`define IN_CNT 16
`define BUF_DEPTH 16
`define HALF_BASE 4'h8
`define TRIG_MANUAL 3'h0
`define TRIG_AUTO 3'h7
`define CHANNEL_COUNT_FIELD_ONE 2'h0
`define CHANNEL_COUNT_FIELD_TWO 2'h1
`define CONV_CYCLES 5'h0c
`define SAR_LAST 4'h9
`endif

//--- adc_seq_pkg.sv
package adc_seq_pkg;
   typedef enum logic [2:0] {
      st_idle,
      st_sample,
      st_wait_trig,
      st_convert,
      st_store
   } state_type;

   typedef struct packed {
      logic [3:0] addr;
      logic [9:0] data;
   } result_type;
endpackage

//--- result_skid.sv
`timescale 1ns/1ps
// two-entry buffer between the converter and the result memory
module result_skid
(
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire adc_seq_pkg::result_type in_data,
   output logic out_valid,
   input wire logic out_ready,
   output adc_seq_pkg::result_type out_data
);
   adc_seq_pkg::result_type mem_q [2];
   logic wr_q;
   logic rd_q;
   logic [1:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rd_q];

   // pointers and occupancy
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'h0;
      end
      else
      begin
         if (push)
            wr_q <= ~wr_q;
         if (pop)
            rd_q <= ~rd_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // storage needs no reset
   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wr_q] <= in_data;
   end
endmodule

//--- adc_seq_checker.sv
`timescale 1ns/1ps
module adc_seq_checker
(
   input wire logic clk,
   input wire logic rst,
   input wire logic module_on_bit,
   input wire logic sample_start_bit,
   input wire logic [2:0] trigger_source_sel,
   input wire logic [1:0] channel_count_field,
   input wire logic ref_ext_sel,
   input wire logic [3:0] sh_sample,
   input wire logic sar_active,
   input wire logic ref_ext,
   input wire logic conversion_irq_flag,
   input wire logic done_bit
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // consecutive busy cycles; saturates so a stuck converter cannot wrap
   logic [3:0] busy_q;
   always_ff @(posedge clk)
   begin
      if (rst || !sar_active)
         busy_q <= 4'h0;
      else if (busy_q != 4'hf)
         busy_q <= busy_q + 4'h1;
   end

   // one conversion holds the converter busy for exactly ten trials
   sequence conv_end;
      $fell(sar_active);
   endsequence
   sequence conv_busy;
      sar_active;
   endsequence
   sequence man_trig;
      trigger_source_sel == 3'h0 && module_on_bit ##0 $fell(sample_start_bit);
   endsequence

   reset_clear_a: assert property (disable iff (1'h0)
      rst |=> !conversion_irq_flag && !done_bit && !sar_active)
      else $error("status not clear after reset");
   conv_length_a: assert property (disable iff (rst || !module_on_bit)
      conv_end |-> busy_q == 4'ha)
      else $error("conversion length wrong");
   conv_cap_a: assert property (conv_busy |-> busy_q < 4'ha)
      else $error("conversion ran too long");
   manual_trig_a: assert property (man_trig |-> ##[1:4] sar_active)
      else $error("manual trigger did not start conversion");
   irq_hold_a: assert property (
      conversion_irq_flag && module_on_bit |=> conversion_irq_flag)
      else $error("flag dropped while module on");
   irq_origin_a: assert property (
      $rose(conversion_irq_flag) |-> $past(module_on_bit))
      else $error("flag raised with module off");
   off_abort_a: assert property (!module_on_bit [*2] |->
      !conversion_irq_flag && !sar_active)
      else $error("module off did not stop converter");
   done_clear_a: assert property (
      module_on_bit && $rose(sample_start_bit) |=> !done_bit)
      else $error("done not cleared by sample start");
   one_chan_a: assert property (
      module_on_bit && channel_count_field == 2'h0 |=> sh_sample[3:1] == 3'h0)
      else $error("extra hold channel used");
   ref_sel_a: assert property (!$past(rst) |->
      ref_ext == $past(ref_ext_sel))
      else $error("reference select not followed");
endmodule

bind adc_sequence_control adc_seq_checker chk (.*);

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clk, rst, module_on_bit, sample_start_bit, ext_trigger, ref_ext;
   logic auto_sample_enable, simultaneous_sample_sel, split_buffer_bit;
   logic alternate_input_bit, scan_enable_bit, ref_ext_sel, sar_active;
   logic conversion_irq_flag, done_bit, rd_req, rd_pend, smp_q;
   logic simul_seen;
   logic [3:0] ch_seen;
   logic [2:0] trigger_source_sel;
   logic [3:0] sequences_per_interrupt, pos_input_primary, sh_sample;
   logic [3:0] pos_input_alternate, read_addr, sh_input_sel;
   logic [1:0] channel_count_field, result_format, sh_channel;
   logic [15:0] scan_select_reg, read_data;
   logic [4:0] auto_sample_clocks;
   logic [9:0] comparator_in, sar_trial, last, old;
   logic [15:0] exp_q[$];
   logic [3:0] sel_q[$];
   int fails, checks_done, cycles, seed, i, m;

   adc_sequence_control uut (.*);

   // free-running bench clock
   initial
   begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input logic [15:0] seen, exp, input string what);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // note the expected word; the monitor compares once read_data lands
   task automatic rd(input logic [3:0] a, input logic [9:0] v);
      @(negedge clk);
      read_addr = a;
      rd_req = 1'h1;
      case (result_format)
         2'h1: exp_q.push_back({{7{~v[9]}}, v[8:0]});
         2'h2: exp_q.push_back({v, 6'h00});
         2'h3: exp_q.push_back({~v[9], v[8:0], 6'h00});
         default: exp_q.push_back({6'h00, v});
      endcase
      @(negedge clk);
      rd_req = 1'h0;
   endtask

   // read_data lags read_addr by one edge, so compare one edge later
   always @(posedge clk)
   begin
      rd_pend <= rd_req;
      if (rd_pend && exp_q.size() > 0)
         chk(read_data, exp_q.pop_front(), "read_data");
   end

   // log the input routed to the first hold channel at each new sample;
   // also note converted channels and an all-four hold while on
   always @(posedge clk)
   begin
      smp_q <= sh_sample[0];
      if (sh_sample[0] && !smp_q)
         sel_q.push_back(sh_input_sel);
      if (!module_on_bit)
         {ch_seen, simul_seen} <= 5'h00;
      else
      begin
         if (sar_active)
            ch_seen[sh_channel] <= 1'h1;
         if (sh_sample == 4'hf)
            simul_seen <= 1'h1;
      end
   end

   // hang guard: the whole run needs only about a thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         tally_and_finish;
      end
   end

   // configuration changes only while the module is off, except result_format in the format test
   task automatic cfg(input logic [1:0] c, input logic [3:0] s,
                      input logic [2:0] t, input logic b);
      channel_count_field = c;
      sequences_per_interrupt = s;
      trigger_source_sel = t;
      split_buffer_bit = b;
      alternate_input_bit = 1'h0;
      scan_enable_bit = 1'h0;
   endtask

   // start sampling; wait for the flag (w) or for the converter
   task automatic run(input logic man, input logic w);
      int n;
      @(negedge clk);
      module_on_bit = 1'h1;
      @(negedge clk);
      sample_start_bit = 1'h1;
      if (man)
      begin
         repeat (3) @(negedge clk);
         sample_start_bit = 1'h0;
      end
      for (n = 0; n < 3000 && (w ? conversion_irq_flag : sar_active) !== 1'h1;
           n++)
         @(negedge clk);
   endtask

   task automatic off;
      @(negedge clk);
      module_on_bit = 1'h0;
      sample_start_bit = 1'h0;
      repeat (2) @(negedge clk);
   endtask

   // three samples: the third shows the restart after the flag
   task automatic sel_run(input logic [3:0] a, b);
      sel_q.delete();
      run(1'h0, 1'h1);
      for (i = 0; i < 500 && sel_q.size() < 3; i++)
         @(negedge clk);
      off;
      chk(sel_q[0], a, "input 0");
      chk(sel_q[1], b, "input 1");
      chk(sel_q[2], a, "input 2");
   endtask

   initial
   begin
      seed = 31;
      rst = 1'h1;
      {module_on_bit, sample_start_bit, ext_trigger, auto_sample_enable,
       simultaneous_sample_sel, split_buffer_bit, alternate_input_bit,
       scan_enable_bit, ref_ext_sel, rd_req} = '0;
      {trigger_source_sel, sequences_per_interrupt, channel_count_field} = '0;
      {scan_select_reg, result_format, pos_input_alternate, read_addr} = '0;
      auto_sample_clocks = 5'h03;
      pos_input_primary = 4'($random(seed));
      last = 10'($random(seed));
      comparator_in = last;
      repeat (6) @(negedge clk);
      rst = 1'h0;
      @(negedge clk);
      chk(conversion_irq_flag, 1'h0, "irq");
      chk(done_bit, 1'h0, "done");
      ref_ext_sel = 1'h1;
      repeat (2) @(negedge clk);
      chk(ref_ext, 1'h1, "ref_ext");
      $display("test reset and reference done");
      // single manual conversion
      run(1'h1, 1'h1);
      chk(conversion_irq_flag, 1'h1, "irq");
      chk(done_bit, 1'h1, "done");
      rd(4'h0, last);
      off;
      chk(conversion_irq_flag, 1'h0, "irq");
      chk(sar_trial, 10'h200, "sar_trial");
      $display("test manual conversion done");
      // four channels, two sequences, sequential then simultaneous
      for (m = 0; m < 2; m++)
      begin
         cfg(2'h2, 4'h1, 3'h7, 1'h0);
         simultaneous_sample_sel = m[0];
         last = 10'($random(seed));
         comparator_in = last;
         run(1'h0, 1'h1);
         chk(ch_seen, 4'hf, "channels");
         chk(simul_seen, m[0], "simultaneous");
         for (i = 0; i < 8; i++)
            rd(i[3:0], last);
         off;
      end
      $display("test channel counts done");
      // split buffer: second batch fills the upper half
      cfg(2'h0, 4'h7, 3'h7, 1'h1);
      old = 10'($random(seed));
      comparator_in = old;
      run(1'h0, 1'h1);
      last = ~old;
      comparator_in = last;
      read_addr = 4'hf;
      for (i = 0; i < 1000 && read_data !== {6'h00, last}; i++)
         @(negedge clk);
      rd(4'h8, last);
      rd(4'h0, old);
      off;
      $display("test split buffer done");
      // scan, plain primary, then alternating input sets
      cfg(2'h0, 4'h1, 3'h7, 1'h0);
      scan_enable_bit = 1'h1;
      scan_select_reg = 16'h0024;
      sel_run(4'h2, 4'h5);
      cfg(2'h0, 4'h0, 3'h7, 1'h0);
      sel_run(pos_input_primary, pos_input_primary);
      alternate_input_bit = 1'h1;
      pos_input_alternate = ~pos_input_primary;
      sel_run(pos_input_primary, pos_input_alternate);
      $display("test input selection done");
      // pin trigger with automatic sampling, then every read format
      cfg(2'h0, 4'h0, 3'h1, 1'h0);
      auto_sample_enable = 1'h1;
      last = 10'($random(seed));
      comparator_in = last;
      @(negedge clk);
      module_on_bit = 1'h1;
      repeat (8) @(negedge clk);
      chk(sar_active, 1'h0, "sar_active");
      ext_trigger = 1'h1;
      for (i = 0; i < 100 && conversion_irq_flag !== 1'h1; i++)
         @(negedge clk);
      ext_trigger = 1'h0;
      chk(conversion_irq_flag, 1'h1, "irq");
      for (m = 0; m < 4; m++)
      begin
         result_format = m[1:0];
         rd(4'h0, last);
      end
      result_format = 2'h0;
      off;
      auto_sample_enable = 1'h0;
      $display("test pin trigger and formats done");
      // abort in mid-conversion keeps the old entry
      cfg(2'h0, 4'h0, 3'h0, 1'h0);
      comparator_in = ~last;
      run(1'h1, 1'h0);
      off;
      rd(4'h0, last);
      repeat (3) @(negedge clk);
      $display("test abort done");
      tally_and_finish;
   end
endmodule
